// >>> rtl/ifd_pkg.sv
// Shared constants, types and helpers for the input function dispatcher.
// Assumes a single 200 MHz clock domain and Avalon-MM byte addressing.
package ifd_pkg;
    localparam int NUM_PORTS = 24;
    localparam int NUM_AUX = 4;
    localparam int CODE_W = 5;
    localparam int NUM_CODES = 32;
    localparam int PORT_IDX_W = 5;
    localparam int ADDR_W = 11;
    localparam int DATA_W = 32;
    localparam int PGM_BITS = 7;
    // Parameter numbers that own the port function codes
    localparam int LO_PORTS = 16;
    localparam int PARAM_BASE_LO = 30;
    localparam int PARAM_BASE_HI = 251;
    localparam logic [CODE_W-1:0] CODE_RESET = 5'h00;
    // Input function codes
    localparam int FN_GP = 0;
    localparam int FN_START_BCD = 1;
    localparam int FN_START_BIN = 2;
    localparam int FN_SOFT_RESET = 3;
    localparam int FN_SERVO = 4;
    localparam int FN_AUTO_START = 5;
    localparam int FN_INTERLOCK = 6;
    localparam int FN_PAUSE_RESET = 7;
    localparam int FN_PAUSE = 8;
    localparam int FN_PGM_BIT1 = 9;
    localparam int FN_ERR_RESET = 16;
    localparam int FN_CUTOFF_RESET = 17;
    localparam int FN_HOME_VALID = 18;
    localparam int FN_HOME_INCR = 19;
    localparam int FN_MOVE_PERMIT = 20;
    localparam int FN_REMOTE_MODE = 21;
    localparam int FN_BRAKE_AX1 = 22;
    localparam int FN_BRAKE_AX2 = 23;
    // Auxiliary pin positions above the input ports in the filter
    localparam int AUX_MODE_AUTO = 0;
    localparam int AUX_BRAKE_NORMAL = 1;
    localparam int AUX_ESTOP_CONT = 2;
    localparam int AUX_CAUSE_CLEAR = 3;
    // Register byte addresses
    localparam logic [ADDR_W-1:0] ADDR_GP_LEVEL = 11'h000;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 11'h004;
    // Timing
    localparam int CLK_MHZ = 200;
    localparam int CLK_KHZ = CLK_MHZ * 1000;
    localparam int DEBOUNCE_TIME_NS = 1000;
    localparam int DEBOUNCE_CYC = (DEBOUNCE_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int SOFT_RESET_HOLD_MS = 1000;
    localparam int SOFT_RESET_HOLD_CYC = SOFT_RESET_HOLD_MS * CLK_KHZ;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_FETCH = 2'b01,
        BUS_DONE = 2'b10
    } ifd_bus_state_type;

    typedef struct packed {
        logic hit;
        logic [PORT_IDX_W-1:0] idx;
    } ifd_port_hit_type;

    typedef struct packed {
        logic homeRequired;
        logic autoMode;
        logic movePermit;
        logic pauseActive;
        logic interlockStop;
        logic servoOn;
    } ifd_status_type;

    // Byte address of a function-code register to its input port
    function automatic ifd_port_hit_type paramToPort(input logic [ADDR_W-1:0] addr);
        ifd_port_hit_type r;
        logic [8:0] n;
        r = '0;
        n = addr[ADDR_W-1:2];
        if (addr[1:0] == 2'h0) begin
            if (n >= 9'(PARAM_BASE_LO) && n < 9'(PARAM_BASE_LO + LO_PORTS)) begin
                r.hit = 1'b1;
                r.idx = PORT_IDX_W'(n - 9'(PARAM_BASE_LO));
            end else if (n >= 9'(PARAM_BASE_HI)
                         && n < 9'(PARAM_BASE_HI + NUM_PORTS - LO_PORTS)) begin
                r.hit = 1'b1;
                r.idx = PORT_IDX_W'(n - 9'(PARAM_BASE_HI) + 9'(LO_PORTS));
            end
        end
        return r;
    endfunction : paramToPort

    // Two BCD digits (units in bits 3:0, tens in bits 6:4) to binary
    function automatic logic [PGM_BITS-1:0] bcdToBin(input logic [PGM_BITS-1:0] b);
        logic [PGM_BITS-1:0] r;
        r = {4'h0, b[6:4]} * 7'h0a + {3'h0, b[3:0]};
        return r;
    endfunction : bcdToBin
endpackage : ifd_pkg

// >>> rtl/ifd_in_filter.sv
// Pin synchroniser and debouncer for a group of asynchronous inputs.
// Assumes pins are unrelated to ref_clk; outputs are stable debounced levels.
`timescale 1ns/100ps
module ifd_in_filter
    import ifd_pkg::*;
#(
    parameter int WIDTH = NUM_PORTS + NUM_AUX,
    parameter int DEBOUNCE = DEBOUNCE_CYC
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] level
);
    localparam int CNT_W = $clog2(DEBOUNCE + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(DEBOUNCE - 1);

    logic [WIDTH-1:0] sync1_q;
    logic [WIDTH-1:0] sync2_q;
    logic [WIDTH-1:0] sync3_q;
    logic [WIDTH-1:0] level_q;
    logic [CNT_W-1:0] cnt_q [WIDTH];

    // A change is seen only when the second and third stages agree
    wire [WIDTH-1:0] agreed = ~(sync2_q ^ sync3_q);
    wire [WIDTH-1:0] differs = agreed & (sync3_q ^ level_q);

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
        end else begin
            sync1_q <= pinIn;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    always_ff @(posedge ref_clk) begin
        for (int i = 0; i < WIDTH; i++) begin
            if (!resetn) begin
                cnt_q[i] <= '0;
                level_q[i] <= 1'b0;
            end else if (!differs[i]) begin
                cnt_q[i] <= '0;
            end else if (cnt_q[i] == CNT_LAST) begin
                cnt_q[i] <= '0;
                level_q[i] <= sync3_q[i];
            end else begin
                cnt_q[i] <= cnt_q[i] + 1'b1;
            end
        end
    end

    assign level = level_q;

    property p_level_stable;
        @(posedge ref_clk) disable iff (!resetn)
        (level_q != $past(level_q)) |-> ($past(agreed) == '1 || $past(differs) != '0);
    endproperty
    a_level_stable: assert property (p_level_stable)
        else $error("debounced level changed without a stable sample");
endmodule : ifd_in_filter

// >>> rtl/ifd_code_mem.sv
// Function-code store, one code per input port, with a registered read port.
// Assumes a single writer; all codes are also presented in parallel.
`timescale 1ns/100ps
module ifd_code_mem
    import ifd_pkg::*;
#(
    parameter int DEPTH = NUM_PORTS,
    parameter int WIDTH = CODE_W
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic wrEn,
    input wire logic [PORT_IDX_W-1:0] wrIdx,
    input wire logic [WIDTH-1:0] wrData,
    input wire logic [PORT_IDX_W-1:0] rdIdx,
    output logic [WIDTH-1:0] rdData,
    output logic [WIDTH-1:0] codes [DEPTH]
);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] rdData_q;

    always_ff @(posedge ref_clk) begin
        for (int i = 0; i < DEPTH; i++) begin
            if (!resetn) begin
                mem_q[i] <= CODE_RESET;
            end else if (wrEn && wrIdx == PORT_IDX_W'(i)) begin
                mem_q[i] <= wrData;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            rdData_q <= '0;
        end else begin
            rdData_q <= mem_q[rdIdx];
        end
    end

    assign rdData = rdData_q;
    assign codes = mem_q;

    property p_write_lands;
        @(posedge ref_clk) disable iff (!resetn)
        wrEn |=> (mem_q[$past(wrIdx)] == $past(wrData));
    endproperty
    a_write_lands: assert property (p_write_lands)
        else $error("function code write did not land in its port slot");
endmodule : ifd_code_mem

// >>> rtl/ifd_dispatch.sv
// Dedicated-input dispatcher: routes each input port to its configured function.
// Assumes the motion logic consumes the one-cycle pulses and levels below.
//
// Design decisions made here: register access over Avalon-MM and the address map.
`timescale 1ns/100ps
// Functional notes
// - Each port owns one function-code parameter
// - Parameter 35 configures port 5
// - Parameters 256 and 257 configure ports 21, 22
// - Code 0 leaves port general purpose
// - Code 1 rising starts BCD program number
// - Code 2 rising starts binary program number
// - Code 3 held one second soft resets
// - Soft reset demands new home return
// - Code 4 edges switch servo on/off
// - Code 6 low stops programs and axes
// - Code 8 low pause latched until code 7
// - Codes 9 to 15 are program bits
// - Code 16 rising clears low-severity errors
// - Code 17 rising resets cutoff when allowed
// - Codes 18, 19 rising command home return
// - Code 20 permits PC and pendant motion
// - Code 21 selects mode when switch auto
// - Codes 22, 23 release brakes in normal
// - Codes 24 to 31 do nothing
module ifd_dispatch
    import ifd_pkg::*;
#(
    parameter int SOFT_RESET_HOLD_CYCLES = SOFT_RESET_HOLD_CYC,
    parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [DATA_W-1:0] avs_writedata,
    output logic [DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [NUM_PORTS-1:0] portIn,
    input wire logic modeSwitchAuto,
    input wire logic brakeNormalPosition,
    input wire logic estopRecoveryContinue,
    input wire logic cutoffCauseCleared,
    input wire logic homeReturnDone,
    output logic programStart,
    output logic [PGM_BITS-1:0] programNumber,
    output logic softReset,
    output logic homeRequired,
    output logic servoOn,
    output logic autoStart,
    output logic abortAll,
    output logic interlockStop,
    output logic pauseActive,
    output logic errorReset,
    output logic cutoffReset,
    output logic homeAllValid,
    output logic homeAllIncremental,
    output logic movePermit,
    output logic autoMode,
    output logic [1:0] brakeRelease
);
    localparam int HOLD_W = $clog2(SOFT_RESET_HOLD_CYCLES + 1);
    localparam logic [HOLD_W-1:0] HOLD_FULL = HOLD_W'(SOFT_RESET_HOLD_CYCLES);
    localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(SOFT_RESET_HOLD_CYCLES - 1);

    logic [NUM_PORTS+NUM_AUX-1:0] filtered;
    logic [CODE_W-1:0] codes [NUM_PORTS];
    logic [CODE_W-1:0] memRdData;
    logic [NUM_CODES-1:0] funcLevel;
    logic [NUM_CODES-1:0] funcAssigned;
    logic [NUM_PORTS-1:0] gpLevel;
    logic [NUM_CODES-1:0] funcLevel_q;
    logic [NUM_PORTS-1:0] gpLevel_q;
    logic [HOLD_W-1:0] holdCnt_q;
    ifd_bus_state_type busState_q;
    logic [DATA_W-1:0] readdata_q;
    logic waitrequest_q;
    ifd_status_type status_q;
    logic programStart_q;
    logic [PGM_BITS-1:0] programNumber_q;
    logic softReset_q;
    logic autoStart_q;
    logic abortAll_q;
    logic errorReset_q;
    logic cutoffReset_q;
    logic homeAllValid_q;
    logic homeAllIncremental_q;
    logic [1:0] brakeRelease_q;

    ifd_in_filter #(
        .WIDTH(NUM_PORTS + NUM_AUX),
        .DEBOUNCE(DEBOUNCE_CYCLES)
    ) u_filter (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .pinIn({cutoffCauseCleared, estopRecoveryContinue, brakeNormalPosition,
                modeSwitchAuto, portIn}),
        .level(filtered)
    );

    wire [NUM_PORTS-1:0] inLevel = filtered[NUM_PORTS-1:0];
    wire auxModeAuto = filtered[NUM_PORTS + AUX_MODE_AUTO];
    wire auxBrakeNormal = filtered[NUM_PORTS + AUX_BRAKE_NORMAL];
    wire auxEstopCont = filtered[NUM_PORTS + AUX_ESTOP_CONT];
    wire auxCauseClear = filtered[NUM_PORTS + AUX_CAUSE_CLEAR];

    // Bus decode
    wire busReq = avs_read | avs_write;
    ifd_port_hit_type portHit;
    assign portHit = paramToPort(avs_address);
    wire memWrEn = (busState_q == BUS_DONE) && avs_write && portHit.hit;
    wire [DATA_W-1:0] statusWord = {{(DATA_W - $bits(ifd_status_type)){1'b0}}, status_q};
    wire [DATA_W-1:0] gpWord = {{(DATA_W - NUM_PORTS){1'b0}}, gpLevel_q};
    wire [DATA_W-1:0] codeWord = {{(DATA_W - CODE_W){1'b0}}, memRdData};
    wire [DATA_W-1:0] readMux = portHit.hit ? codeWord :
                                (avs_address == ADDR_GP_LEVEL) ? gpWord :
                                (avs_address == ADDR_STATUS) ? statusWord : '0;

    ifd_code_mem #(
        .DEPTH(NUM_PORTS),
        .WIDTH(CODE_W)
    ) u_codes (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .wrEn(memWrEn),
        .wrIdx(portHit.idx),
        .wrData(avs_writedata[CODE_W-1:0]),
        .rdIdx(portHit.idx),
        .rdData(memRdData),
        .codes(codes)
    );

    // Gather port levels per function code; unused codes simply fan out nowhere
    always_comb begin
        funcLevel = '0;
        funcAssigned = '0;
        gpLevel = '0;
        for (int p = 0; p < NUM_PORTS; p++) begin
            funcAssigned[codes[p]] = 1'b1;
            if (inLevel[p]) begin
                funcLevel[codes[p]] = 1'b1;
            end
            gpLevel[p] = inLevel[p] && (codes[p] == CODE_W'(FN_GP));
        end
    end

    // One-cycle edge events per function code
    wire [NUM_CODES-1:0] funcRise = funcLevel & ~funcLevel_q;
    wire [NUM_CODES-1:0] funcFall = ~funcLevel & funcLevel_q;
    // Program-number bits, code 9 in bit 0
    wire [PGM_BITS-1:0] pgmBits = funcLevel[FN_PGM_BIT1 +: PGM_BITS];
    wire holdDone = funcLevel[FN_SOFT_RESET] && holdCnt_q == HOLD_LAST;
    wire pauseSet = funcAssigned[FN_PAUSE] && !funcLevel[FN_PAUSE];
    wire pauseClr = funcRise[FN_PAUSE_RESET] && funcLevel[FN_PAUSE];
    wire modeAuto = auxModeAuto && (!funcAssigned[FN_REMOTE_MODE]
                                    || funcLevel[FN_REMOTE_MODE]);

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            funcLevel_q <= '0;
            gpLevel_q <= '0;
        end else begin
            funcLevel_q <= funcLevel;
            gpLevel_q <= gpLevel;
        end
    end

    // Soft reset hold timer
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            holdCnt_q <= '0;
        end else if (!funcLevel[FN_SOFT_RESET]) begin
            holdCnt_q <= '0;
        end else if (holdCnt_q != HOLD_FULL) begin
            holdCnt_q <= holdCnt_q + 1'b1;
        end
    end

    // Program start
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            programStart_q <= 1'b0;
            programNumber_q <= '0;
        end else begin
            programStart_q <= funcRise[FN_START_BCD] | funcRise[FN_START_BIN];
            if (funcRise[FN_START_BCD]) begin
                programNumber_q <= bcdToBin(pgmBits);
            end else if (funcRise[FN_START_BIN]) begin
                programNumber_q <= pgmBits;
            end
        end
    end

    // Event pulses
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            softReset_q <= 1'b0;
            autoStart_q <= 1'b0;
            abortAll_q <= 1'b0;
            errorReset_q <= 1'b0;
            cutoffReset_q <= 1'b0;
            homeAllValid_q <= 1'b0;
            homeAllIncremental_q <= 1'b0;
        end else begin
            softReset_q <= holdDone;
            autoStart_q <= funcRise[FN_AUTO_START];
            abortAll_q <= funcFall[FN_AUTO_START];
            errorReset_q <= funcRise[FN_ERR_RESET];
            cutoffReset_q <= funcRise[FN_CUTOFF_RESET] && auxEstopCont && auxCauseClear;
            homeAllValid_q <= funcRise[FN_HOME_VALID];
            homeAllIncremental_q <= funcRise[FN_HOME_INCR];
        end
    end

    // Levels and latched state
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            status_q <= '0;
            status_q.homeRequired <= 1'b1;
            brakeRelease_q <= '0;
        end else begin
            if (holdDone) begin
                status_q.homeRequired <= 1'b1;
            end else if (homeReturnDone) begin
                status_q.homeRequired <= 1'b0;
            end
            if (funcRise[FN_SERVO]) begin
                status_q.servoOn <= 1'b1;
            end else if (funcFall[FN_SERVO]) begin
                status_q.servoOn <= 1'b0;
            end
            status_q.interlockStop <= funcAssigned[FN_INTERLOCK] && !funcLevel[FN_INTERLOCK];
            if (pauseSet) begin
                status_q.pauseActive <= 1'b1;
            end else if (pauseClr) begin
                status_q.pauseActive <= 1'b0;
            end
            status_q.movePermit <= funcLevel[FN_MOVE_PERMIT];
            status_q.autoMode <= modeAuto;
            brakeRelease_q <= {funcLevel[FN_BRAKE_AX2], funcLevel[FN_BRAKE_AX1]}
                              & {2{auxBrakeNormal}};
        end
    end

    // Avalon slave: fetch, answer, then commit
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            busState_q <= BUS_IDLE;
            waitrequest_q <= 1'b1;
            readdata_q <= '0;
        end else begin
            case (busState_q)
                BUS_IDLE: begin
                    if (busReq) begin
                        busState_q <= BUS_FETCH;
                    end
                end
                BUS_FETCH: begin
                    busState_q <= BUS_DONE;
                    waitrequest_q <= 1'b0;
                    readdata_q <= avs_read ? readMux : '0;
                end
                BUS_DONE: begin
                    busState_q <= BUS_IDLE;
                    waitrequest_q <= 1'b1;
                end
                default: begin
                    busState_q <= BUS_IDLE;
                    waitrequest_q <= 1'b1;
                end
            endcase
        end
    end

    assign avs_readdata = readdata_q;
    assign avs_waitrequest = waitrequest_q;
    assign programStart = programStart_q;
    assign programNumber = programNumber_q;
    assign softReset = softReset_q;
    assign homeRequired = status_q.homeRequired;
    assign servoOn = status_q.servoOn;
    assign autoStart = autoStart_q;
    assign abortAll = abortAll_q;
    assign interlockStop = status_q.interlockStop;
    assign pauseActive = status_q.pauseActive;
    assign errorReset = errorReset_q;
    assign cutoffReset = cutoffReset_q;
    assign homeAllValid = homeAllValid_q;
    assign homeAllIncremental = homeAllIncremental_q;
    assign movePermit = status_q.movePermit;
    assign autoMode = status_q.autoMode;
    assign brakeRelease = brakeRelease_q;

    property p_start_bcd;
        @(posedge ref_clk) disable iff (!resetn)
        funcRise[FN_START_BCD] |=> programStart_q && programNumber_q == bcdToBin($past(pgmBits));
    endproperty
    a_start_bcd: assert property (p_start_bcd)
        else $error("BCD start gave wrong program number");

    property p_start_bin;
        @(posedge ref_clk) disable iff (!resetn)
        funcRise[FN_START_BIN] && !funcRise[FN_START_BCD]
            |=> programStart_q && programNumber_q == $past(pgmBits);
    endproperty
    a_start_bin: assert property (p_start_bin)
        else $error("binary start gave wrong program number");

    property p_servo;
        @(posedge ref_clk) disable iff (!resetn)
        funcFall[FN_SERVO] |=> !servoOn ##1 (servoOn == $past(funcLevel[FN_SERVO]) || servoOn == 1'b0);
    endproperty
    a_servo: assert property (p_servo)
        else $error("servo did not follow the servo input edge");

    property p_soft_reset_home;
        @(posedge ref_clk) disable iff (!resetn)
        softReset_q |-> homeRequired && $past(funcLevel[FN_SOFT_RESET], 2);
    endproperty
    a_soft_reset_home: assert property (p_soft_reset_home)
        else $error("soft reset without held input or home flag");

    property p_abort;
        @(posedge ref_clk) disable iff (!resetn)
        funcFall[FN_AUTO_START] |=> abortAll_q && !autoStart_q;
    endproperty
    a_abort: assert property (p_abort)
        else $error("auto-start falling edge did not abort");

    property p_interlock;
        @(posedge ref_clk) disable iff (!resetn)
        (funcAssigned[FN_INTERLOCK] && !funcLevel[FN_INTERLOCK]) |=> interlockStop;
    endproperty
    a_interlock: assert property (p_interlock)
        else $error("interlock low did not stop motion");

    property p_pause_hold;
        @(posedge ref_clk) disable iff (!resetn)
        pauseActive && !pauseClr |=> pauseActive;
    endproperty
    a_pause_hold: assert property (p_pause_hold)
        else $error("pause released without a reset edge");

    property p_brake;
        @(posedge ref_clk) disable iff (!resetn)
        !auxBrakeNormal |=> brakeRelease == 2'h0;
    endproperty
    a_brake: assert property (p_brake)
        else $error("brake released outside normal position");

    property p_bus_answer;
        @(posedge ref_clk) disable iff (!resetn)
        (busState_q == BUS_IDLE && busReq) |=> waitrequest_q ##1 !waitrequest_q ##1 waitrequest_q;
    endproperty
    a_bus_answer: assert property (p_bus_answer)
        else $error("bus answer not on the third edge");
endmodule : ifd_dispatch

// >>> test/ifd_plc_model.sv
// Far-side controller model driving the dedicated input pins.
// Assumes the bench supplies wanted levels; pins follow on the next edge.
`timescale 1ns/100ps
module ifd_plc_model
    import ifd_pkg::*;
(
    input wire logic ref_clk,
    input wire logic [NUM_PORTS-1:0] want,
    output logic [NUM_PORTS-1:0] portIn
);
    // Servo goes on before homing, resets are held, program bits run upward
    always_ff @(posedge ref_clk) portIn <= want;
endmodule : ifd_plc_model

// >>> test/testbench.sv
// Self-checking bench: register bus tasks, pin stimulus, pulse counting.
// Assumes ifd_dispatch with short debounce and soft reset hold counts.
`timescale 1ns/100ps
module testbench;
    import ifd_pkg::*;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic avs_waitrequest;
    logic [ADDR_W-1:0] avs_address = 11'h000;
    logic [DATA_W-1:0] avs_writedata = 32'h0;
    logic [DATA_W-1:0] avs_readdata;
    logic [DATA_W-1:0] rd;
    logic [NUM_PORTS-1:0] want = 24'h0;
    logic [NUM_PORTS-1:0] portIn;
    logic programStart, softReset, homeAllValid, servoOn;
    logic autoStart, abortAll, errorReset, cutoffReset, homeAllIncremental;
    logic brkNorm = 1'b1;
    logic homeDone = 1'b0;
    wire [5:1] lv;
    int evts = 0;
    int cfg [12] = '{5, 16, 17, 19, 6, 24, 8, 7, 20, 0, 23, 21};
    logic [PGM_BITS-1:0] programNumber;
    logic [1:0] brakeRelease;
    int mismatches = 0;
    int samples_checked = 0;
    int pulses = 0;
    int expP = 0;
    int v;
    initial forever #2.5 ref_clk = ~ref_clk;
    ifd_plc_model ifd_plc_model_i (.ref_clk(ref_clk), .want(want), .portIn(portIn));
    ifd_dispatch #(.SOFT_RESET_HOLD_CYCLES(20), .DEBOUNCE_CYCLES(3)) ifd_dispatch_i (
        .ref_clk(ref_clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .portIn(portIn), .modeSwitchAuto(1'b1),
        .brakeNormalPosition(brkNorm), .estopRecoveryContinue(1'b1), .cutoffCauseCleared(1'b1),
        .homeReturnDone(homeDone), .programStart(programStart), .programNumber(programNumber),
        .softReset(softReset), .homeRequired(lv[5]), .servoOn(servoOn), .autoStart(autoStart),
        .abortAll(abortAll), .interlockStop(lv[1]), .pauseActive(lv[2]),
        .errorReset(errorReset), .cutoffReset(cutoffReset), .homeAllValid(homeAllValid),
        .homeAllIncremental(homeAllIncremental), .movePermit(lv[3]), .autoMode(lv[4]),
        .brakeRelease(brakeRelease));
    always @(posedge ref_clk) evts <= evts + int'(autoStart) + 2 * int'(abortAll)
        + 4 * int'(errorReset) + 8 * int'(cutoffReset) + 16 * int'(homeAllIncremental);
    always @(posedge ref_clk) pulses <= pulses + int'(programStart) + int'(softReset)
        + int'(homeAllValid);
    task automatic test_done;
        $display("Compared %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : test_done
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // One Avalon access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n >= 50) begin
            mismatches++;
            test_done();
        end
        @(posedge ref_clk);
    endtask : bus
    function automatic logic [ADDR_W-1:0] pa(input int p);
        return ADDR_W'(4 * (p < 16 ? 30 + p : 235 + p));
    endfunction : pa
    function automatic logic [31:0] bcd(input logic [6:0] b);
        return 32'(b[6:4]) * 32'h0a + 32'(b[3:0]);
    endfunction : bcd
    task automatic drive(input logic [NUM_PORTS-1:0] w, input int hold);
        want <= w;
        repeat (hold) @(posedge ref_clk);
    endtask : drive
    initial begin
        v = $urandom(32'hf1f1);
        repeat (12) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk(rd, 32'h20);
        bus(1'b0, 11'h7fc, 32'h0);
        chk(rd, 32'h0);
        bus(1'b1, 11'h08c, 32'd22);
        bus(1'b0, pa(5), 32'h0);
        chk(rd, 32'd22);
        bus(1'b1, 11'h400, 32'd24);
        bus(1'b1, 11'h404, 32'd24);
        bus(1'b1, 11'h400, 32'h0);
        bus(1'b1, 11'h404, 32'h0);
        drive(24'h600020, 12);
        chk(32'(brakeRelease), 32'h1);
        bus(1'b0, ADDR_GP_LEVEL, 32'h0);
        chk(rd, 32'h600000);
        for (int p = 0; p < 7; p++) bus(1'b1, pa(p), 32'(9 + p));
        bus(1'b1, pa(7), 32'd2);
        bus(1'b1, pa(8), 32'd1);
        bus(1'b1, pa(9), 32'd4);
        bus(1'b1, pa(10), 32'd18);
        bus(1'b1, pa(11), 32'd3);
        bus(1'b1, pa(17), 32'd24);
        bus(1'b0, pa(17), 32'h0);
        chk(rd, 32'd24);
        for (int i = 0; i < 6; i++) begin
            v = (i == 0) ? 127 : (i[0] ? ($urandom % 8) * 16 + $urandom % 10 : $urandom % 128);
            drive(24'(v), 12);
            drive(24'(v) | (i[0] ? 24'h100 : 24'h080), 12);
            expP++;
            chk(32'(programNumber), i[0] ? bcd(7'(v)) : 32'(v));
            chk(32'(pulses), 32'(expP));
        end
        drive(24'h000200, 12);
        chk(32'(servoOn), 32'h1);
        drive(24'h000600, 12);
        expP++;
        chk(32'(pulses), 32'(expP));
        homeDone <= 1'b1;
        @(posedge ref_clk);
        homeDone <= 1'b0;
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk(32'(rd[5]), 32'h0);
        drive(24'h020a00, 40);
        drive(24'h000000, 12);
        expP++;
        chk(32'(pulses), 32'(expP));
        chk(32'(servoOn), 32'h0);
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk(rd, 32'h30);
        for (int p = 12; p < 24; p++) bus(1'b1, pa(p), 32'(cfg[p - 12]));
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk(rd, 32'h26);
        drive(24'h95f000, 12);
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk(rd, 32'h3c);
        chk(32'({lv, servoOn}), 32'h3c);
        chk(32'(evts), 32'd29);
        drive(24'h9de000, 12);
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk(rd, 32'h38);
        chk(32'(evts), 32'd31);
        brkNorm <= 1'b0;
        drive(24'hdde000, 12);
        chk(32'(brakeRelease), 32'h0);
        brkNorm <= 1'b1;
        drive(24'hdde000, 12);
        chk(32'(brakeRelease), 32'h2);
        test_done();
    end
endmodule : testbench
